// ---- rtl/fpt_pkg.sv ----
// fpt_pkg: constants for the fp port and trap control block
// assumes one 10 MHz clock and an AXI4-Lite register slave
package fpt_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_TRAP = 8'h08;
	localparam logic [7:0] ADDR_PCS = 8'h0C;
	// control register fields
	localparam int CTRL_TEN = 0;
	localparam int CTRL_MASK_LO = 4;
	localparam int CTRL_MASK_HI = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// trap type codes
	localparam logic [7:0] TT_FP_DISABLED = 8'h04;
	localparam logic [7:0] TT_FP_EXCEPTION = 8'h08;
	localparam logic [7:0] TT_PARITY = 8'h20;
	localparam logic [7:0] TT_IRQ_BASE = 8'h10;
	localparam logic [3:0] IRQ_NONE = 4'h0;
	localparam logic [3:0] IRQ_NMI = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_RUN, ST_TRAP, ST_ERROR} fpt_state_t;
endpackage : fpt_pkg

// ---- rtl/fpt_parity.sv ----
// fpt_parity: odd parity generator over a small vector
// assumes a combinational use only
`timescale 1ns/1ns
module fpt_parity #(parameter int W = 5) (
	// data in
	input wire logic [W-1:0] bits,
	// odd parity out
	output logic par
);
	assign par = ~(^bits);
endmodule : fpt_parity

// ---- rtl/fpt_trap_ctrl.sv ----
// fpt_trap_ctrl: integer-side fp port, trap, error and interrupt control
// assumes fp unit inputs synchronous to mclk; decode info comes from the pipeline
`timescale 1ns/1ns
module fpt_trap_ctrl (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// axi4-lite write address/data/response
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pipeline side
	input wire logic fetchReq,
	input wire logic decodeFpFirst,
	input wire logic decodeFpSecond,
	input wire logic executeFpInstr,
	input wire logic [31:0] pcIn,
	input wire logic [31:0] npcIn,
	input wire logic syncTrapReq,
	input wire logic [7:0] syncTrapType,
	input wire logic internalParityErr,
	output logic pipeStall,
	output logic trapTaken,
	// fp unit link
	input wire logic [1:0] fpCondCodes,
	input wire logic fpCondValid,
	input wire logic cpCondValid,
	input wire logic fpExceptionRequest,
	input wire logic fpHold,
	input wire logic fpuToIuParity,
	input wire logic fpPresentN,
	output logic fpIssueFirst,
	output logic fpIssueSecond,
	output logic fpFlush,
	output logic fpExceptionAck,
	output logic instrFetchStrobe,
	output logic iuToFpuParity,
	output logic iuToFpuParityOe,
	// control pins
	input wire logic testOutputEnableN,
	input wire logic checkerSelectN,
	input wire logic inputParityDisableN,
	input wire logic [10:0] masterPins,
	output logic errorMode,
	output logic hwParityErrorN,
	output logic compareMismatchN,
	output logic linkOe,
	// interrupts
	input wire logic [3:0] irqLevel,
	output logic irqTakenAck
);
	fpt_pkg::fpt_state_t state_q;
	logic [31:0] ctrl_q;
	logic [7:0] trapType_q;
	logic [31:0] savedPc_q, savedNpc_q;
	logic holdR_q, excR_q, ccvR_q, cpvR_q, parR_q;
	logic [1:0] fccR_q;
	logic [3:0] irqS1_q, irqS2_q;
	logic fpExceptionAck_q, instrFetchStrobe_q, irqTakenAck_q, flush_q;
	logic parErr_q;
	logic inParBad, parityErr, trapFpDis, trapFpExc, irqPending, anyTrap, trapEnable;
	logic [3:0] maskLvl;
	logic [7:0] trapTypeD;
	logic outPar;
	logic awHave_q, wHave_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic doWrite;
	// input registers, used only after capture
	always_ff @(posedge mclk) begin
		if (rst) begin
			holdR_q <= 1'b0;
			excR_q <= 1'b0;
			ccvR_q <= 1'b1;
			cpvR_q <= 1'b1;
			fccR_q <= 2'h0;
			parR_q <= 1'b1;
		end else begin
			holdR_q <= fpHold;
			excR_q <= fpExceptionRequest;
			ccvR_q <= fpCondValid;
			cpvR_q <= cpCondValid;
			fccR_q <= fpCondCodes;
			parR_q <= fpuToIuParity;
		end
	end
	// odd parity over fcc, ccv, exc and hold including the parity bit itself
	assign inParBad = ~(^{fccR_q, ccvR_q, excR_q, holdR_q, parR_q});
	assign parityErr = inParBad & inputParityDisableN;
	assign pipeStall = holdR_q | ~ccvR_q | ~cpvR_q | (state_q != fpt_pkg::ST_RUN);
	assign trapEnable = ctrl_q[fpt_pkg::CTRL_TEN];
	assign maskLvl = ctrl_q[fpt_pkg::CTRL_MASK_HI:fpt_pkg::CTRL_MASK_LO];
	// interrupts: a level counts once irqS2_q and irqStable_q agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			irqS1_q <= fpt_pkg::IRQ_NONE;
			irqS2_q <= fpt_pkg::IRQ_NONE;
		end else begin
			irqS1_q <= irqLevel;
			irqS2_q <= irqS1_q;
		end
	end
	// irqStable_q follows irqS2_q one cycle later, so comparing the two needs the same irqS2_q level on two samples
	logic [3:0] irqStable_q;
	always_ff @(posedge mclk) begin
		if (rst) irqStable_q <= fpt_pkg::IRQ_NONE;
		else if (irqS2_q == irqStable_q || 1'b1) irqStable_q <= irqS2_q;
	end
	assign irqPending = (irqS2_q == irqStable_q) && (irqS2_q != fpt_pkg::IRQ_NONE)
		&& ((irqS2_q == fpt_pkg::IRQ_NMI) || (irqS2_q > maskLvl));
	// trap selection: fp traps wait for an executing fp instruction
	assign trapFpDis = executeFpInstr & fpPresentN;
	assign trapFpExc = executeFpInstr & ~fpPresentN & excR_q & ~fpExceptionAck_q;
	assign anyTrap = (state_q == fpt_pkg::ST_RUN) && !holdR_q
		&& (syncTrapReq || trapFpDis || trapFpExc || parityErr || (irqPending && trapEnable));
	always_comb begin
		trapTypeD = syncTrapType;
		if (parityErr) trapTypeD = fpt_pkg::TT_PARITY;
		else if (trapFpDis) trapTypeD = fpt_pkg::TT_FP_DISABLED;
		else if (trapFpExc) trapTypeD = fpt_pkg::TT_FP_EXCEPTION;
		else if (!syncTrapReq) trapTypeD = fpt_pkg::TT_IRQ_BASE | {4'h0, irqS2_q};
	end
	assign trapTaken = anyTrap;
	// trap state machine
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= fpt_pkg::ST_RUN;
			trapType_q <= 8'h00;
			savedPc_q <= 32'h0000_0000;
			savedNpc_q <= 32'h0000_0000;
		end else begin
			unique case (state_q)
				fpt_pkg::ST_RUN: begin
					if (anyTrap) begin
						trapType_q <= trapTypeD;
						savedPc_q <= pcIn;
						savedNpc_q <= npcIn;
						// only a reset leaves error mode
						state_q <= trapEnable ? fpt_pkg::ST_TRAP : fpt_pkg::ST_ERROR;
					end
				end
				fpt_pkg::ST_TRAP: state_q <= fpt_pkg::ST_RUN;
				fpt_pkg::ST_ERROR: state_q <= fpt_pkg::ST_ERROR;
			endcase
		end
	end
	assign errorMode = (state_q == fpt_pkg::ST_ERROR);
	// registered strobes toward the fp unit, plus the interrupt ack and the parity error flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			fpExceptionAck_q <= 1'b0;
			instrFetchStrobe_q <= 1'b0;
			irqTakenAck_q <= 1'b0;
			flush_q <= 1'b0;
			parErr_q <= 1'b0;
		end else begin
			fpExceptionAck_q <= (anyTrap && trapFpExc && !parityErr && !trapFpDis)
				|| (fpExceptionAck_q && excR_q);
			instrFetchStrobe_q <= fetchReq && !pipeStall && !errorMode;
			irqTakenAck_q <= anyTrap && !syncTrapReq && !trapFpDis && !trapFpExc && !parityErr;
			flush_q <= anyTrap;
			parErr_q <= parityErr;
		end
	end
	// issue strobes: first buffer wins, never both
	assign fpIssueFirst = decodeFpFirst && !pipeStall && !fpFlush;
	assign fpIssueSecond = decodeFpSecond && !decodeFpFirst && !pipeStall && !fpFlush;
	assign fpFlush = flush_q;
	assign fpExceptionAck = fpExceptionAck_q;
	assign instrFetchStrobe = instrFetchStrobe_q;
	assign irqTakenAck = irqTakenAck_q;
	assign hwParityErrorN = ~parErr_q;
	fpt_parity #(.W(5)) u_outPar (
		.bits({fpIssueFirst, fpIssueSecond, fpFlush, fpExceptionAck, instrFetchStrobe}),
		.par(outPar)
	);
	assign iuToFpuParity = outPar;
	assign iuToFpuParityOe = ~testOutputEnableN & checkerSelectN;
	assign linkOe = ~testOutputEnableN & checkerSelectN;
	// checker compare: masterPins[5:0] in order issue1, issue2, flush, ack, fetch, par; err, irqack, stall, trap, rsv not compared
	assign compareMismatchN = checkerSelectN | (masterPins[5:0] ==
		{outPar, instrFetchStrobe, fpExceptionAck, fpFlush, fpIssueSecond, fpIssueFirst});
	// axi4-lite write path; address and data may come in either order
	assign awready = !awHave_q && !bvalid;
	assign wready = !wHave_q && !bvalid;
	assign doWrite = awHave_q && wHave_q && !bvalid;
	always_ff @(posedge mclk) begin
		if (rst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= fpt_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awAddr_q == fpt_pkg::ADDR_CTRL) ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	// control register, byte lanes honoured
	always_ff @(posedge mclk) begin
		if (rst) ctrl_q <= fpt_pkg::CTRL_RESET;
		else if (doWrite && awAddr_q == fpt_pkg::ADDR_CTRL) begin
			for (int i = 0; i < 4; i++) begin
				if (wStrb_q[i]) ctrl_q[i*8 +: 8] <= wData_q[i*8 +: 8];
			end
		end
	end
	// axi4-lite read path
	assign arready = !rvalid;
	always_ff @(posedge mclk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= fpt_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= fpt_pkg::RESP_OKAY;
			unique case (araddr)
				fpt_pkg::ADDR_CTRL: rdata <= ctrl_q;
				fpt_pkg::ADDR_STAT: rdata <= {24'h0, irqS2_q, parErr_q, holdR_q, errorMode, excR_q};
				fpt_pkg::ADDR_TRAP: rdata <= {24'h0, trapType_q};
				fpt_pkg::ADDR_PCS: rdata <= savedPc_q ^ savedNpc_q;
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= fpt_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule : fpt_trap_ctrl

// ---- test/fpt_trap_ctrl_props.sv ----
// fpt_trap_ctrl_props: port checks of the fp link and trap pins
// assumes a bind onto fpt_trap_ctrl, one mclk domain
`timescale 1ns/1ns
module fpt_trap_ctrl_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched pins
	input wire logic fetchReq,
	input wire logic fpHold,
	input wire logic pipeStall,
	input wire logic trapTaken,
	input wire logic fpIssueFirst,
	input wire logic fpIssueSecond,
	input wire logic fpFlush,
	input wire logic fpExceptionAck,
	input wire logic instrFetchStrobe,
	input wire logic iuToFpuParity,
	input wire logic iuToFpuParityOe,
	input wire logic errorMode,
	input wire logic irqTakenAck
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	AST_ISSUE_EXCL: assert property (!(fpIssueFirst && fpIssueSecond))
		else $error("both issue strobes high");
	AST_FLUSH_TRAP: assert property (trapTaken |=> fpFlush)
		else $error("no flush after trap");
	AST_ACK_CAUSE: assert property ($rose(fpExceptionAck) |-> $past(trapTaken))
		else $error("ack without trap");
	AST_FETCH: assert property (fetchReq && !pipeStall |=> instrFetchStrobe)
		else $error("fetch strobe missing");
	AST_PARITY: assert property (iuToFpuParityOe |-> ^{fpIssueFirst, fpIssueSecond, fpFlush,
		fpExceptionAck, instrFetchStrobe, iuToFpuParity})
		else $error("link parity not odd");
	AST_HOLD_STALL: assert property (fpHold |=> pipeStall)
		else $error("hold did not stall");
	AST_ERROR_STICKY: assert property (errorMode |=> errorMode)
		else $error("error mode left");
	AST_IRQ_ACK: assert property ($rose(irqTakenAck) |-> $past(trapTaken))
		else $error("irq ack without trap");
endmodule : fpt_trap_ctrl_props

// ---- test/fpt_fpu_model.sv ----
// fpt_fpu_model: behavioural far-side fp unit
// assumes the bench pulses raiseExc and levels holdReq
`timescale 1ns/1ns
module fpt_fpu_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bench control
	input wire logic raiseExc,
	input wire logic holdReq,
	// link
	input wire logic fpExceptionAck,
	output logic [1:0] fpCondCodes,
	output logic fpCondValid,
	output logic fpExceptionRequest,
	output logic fpHold
);
	always_ff @(posedge mclk) begin
		if (rst)
			fpExceptionRequest <= 1'b0;
		else if (raiseExc)
			fpExceptionRequest <= 1'b1;
		else if (fpExceptionAck)
			fpExceptionRequest <= 1'b0;
	end
	// hold falls a cycle after the request rises, so the request leads
	always_ff @(posedge mclk)
		fpHold <= !rst && holdReq && !fpExceptionRequest;
	assign fpCondCodes = 2'h2;
	assign fpCondValid = 1'b1;
endmodule : fpt_fpu_model

// ---- test/fpt_trap_ctrl_tb.sv ----
// fpt_trap_ctrl_tb: directed bench for the fp port and trap block
// assumes fpt_pkg, the design and the fp unit model compiled first
`timescale 1ns/1ns
module fpt_trap_ctrl_tb;
	logic mclk = '0, rst = '1, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic fetchReq = '0, decodeFpFirst = '0, executeFpInstr = '0, syncTrapReq = '0, fpPresentN = '0;
	logic testOutputEnableN = '0, raiseExc = '0, holdReq = '0, fpCondValid, fpExceptionRequest, fpHold;
	logic decodeFpSecond = '0, cpCondValid = '1, checkerSelectN = '1, inputParityDisableN = '1;
	logic [7:0] awaddr = '0, araddr = '0, syncTrapType = '0;
	logic [31:0] wdata = '0, rdata, rd;
	logic [3:0] irqLevel = '0;
	logic [1:0] resp, bresp, rresp, fpCondCodes;
	logic awready, wready, bvalid, arready, rvalid, pipeStall, trapTaken, fpIssueFirst, fpIssueSecond;
	logic fpFlush, fpExceptionAck, instrFetchStrobe, iuToFpuParity, iuToFpuParityOe, errorMode, irqTakenAck;
	int failures = 0, cmpCount = 0, n;
	always #50 mclk = ~mclk;
	fpt_fpu_model fpt_fpu_model_i (.mclk(mclk), .rst(rst), .raiseExc(raiseExc), .holdReq(holdReq),
		.fpExceptionAck(fpExceptionAck), .fpCondCodes(fpCondCodes), .fpCondValid(fpCondValid),
		.fpExceptionRequest(fpExceptionRequest), .fpHold(fpHold));
	// odd parity over the link, kept as the far side would
	wire logic fpuToIuParity = ~^{fpCondCodes, fpCondValid, fpExceptionRequest, fpHold};
	fpt_trap_ctrl fpt_trap_ctrl_i (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fetchReq(fetchReq),
		.decodeFpFirst(decodeFpFirst), .decodeFpSecond(decodeFpSecond), .executeFpInstr(executeFpInstr),
		.pcIn(32'h0000_0100), .npcIn(32'h0000_0104), .syncTrapReq(syncTrapReq), .syncTrapType(syncTrapType),
		.internalParityErr(1'b0), .pipeStall(pipeStall), .trapTaken(trapTaken), .fpCondCodes(fpCondCodes),
		.fpCondValid(fpCondValid), .cpCondValid(cpCondValid), .fpExceptionRequest(fpExceptionRequest),
		.fpHold(fpHold), .fpuToIuParity(fpuToIuParity), .fpPresentN(fpPresentN), .fpIssueFirst(fpIssueFirst),
		.fpIssueSecond(fpIssueSecond), .fpFlush(fpFlush), .fpExceptionAck(fpExceptionAck),
		.instrFetchStrobe(instrFetchStrobe), .iuToFpuParity(iuToFpuParity), .iuToFpuParityOe(iuToFpuParityOe),
		.testOutputEnableN(testOutputEnableN), .checkerSelectN(checkerSelectN),
		.inputParityDisableN(inputParityDisableN),
		.masterPins(11'h000), .errorMode(errorMode), .hwParityErrorN(), .compareMismatchN(), .linkOe(),
		.irqLevel(irqLevel), .irqTakenAck(irqTakenAck));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic pulse_exec;
		executeFpInstr <= 1'b1;
		@(posedge mclk);
		executeFpInstr <= 1'b0;
		for (n = 0; n < 20 && !fpFlush; n++) @(posedge mclk);
	endtask : pulse_exec
	task automatic t_regs;
		axi_rd(fpt_pkg::ADDR_CTRL);
		check(rd, fpt_pkg::CTRL_RESET);
		axi_wr(fpt_pkg::ADDR_CTRL, 32'h0000_00F1);
		axi_rd(fpt_pkg::ADDR_CTRL);
		check(rd, 32'h0000_00F1);
		axi_wr(fpt_pkg::ADDR_STAT, 32'h0000_0001);
		check(resp, fpt_pkg::RESP_SLVERR);
		axi_rd(8'h40);
		check(resp, fpt_pkg::RESP_SLVERR);
	endtask : t_regs
	task automatic t_exc;
		raiseExc <= 1'b1;
		@(posedge mclk);
		raiseExc <= 1'b0;
		repeat (5) @(posedge mclk);
		check(fpExceptionAck, 1'b0);
		pulse_exec();
		check({fpFlush, fpExceptionAck}, 2'h3);
		repeat (4) @(posedge mclk);
		check({fpExceptionRequest, fpExceptionAck}, 2'h0);
		axi_rd(fpt_pkg::ADDR_TRAP);
		check(rd[7:0], fpt_pkg::TT_FP_EXCEPTION);
		fpPresentN <= 1'b1;
		repeat (2) @(posedge mclk);
		pulse_exec();
		check(fpFlush, 1'b1);
		fpPresentN <= 1'b0;
		axi_rd(fpt_pkg::ADDR_TRAP);
		check(rd[7:0], fpt_pkg::TT_FP_DISABLED);
	endtask : t_exc
	task automatic t_pipe;
		fetchReq <= 1'b1;
		decodeFpFirst <= 1'b1;
		repeat (2) @(posedge mclk);
		check({instrFetchStrobe, fpIssueFirst}, 2'h3);
		holdReq <= 1'b1;
		// hold passes the model flop and the input register before the fetch strobe sees it
		repeat (4) @(posedge mclk);
		check({pipeStall, instrFetchStrobe}, 2'h2);
		testOutputEnableN <= 1'b1;
		holdReq <= 1'b0;
		fetchReq <= 1'b0;
		decodeFpFirst <= 1'b0;
		repeat (2) @(posedge mclk);
		check(iuToFpuParityOe, 1'b0);
		testOutputEnableN <= 1'b0;
	endtask : t_pipe
	task automatic t_modes;
		decodeFpFirst <= 1'b1;
		decodeFpSecond <= 1'b1;
		@(posedge mclk);
		check({fpIssueFirst, fpIssueSecond}, 2'h2);
		decodeFpFirst <= 1'b0;
		@(posedge mclk);
		check({fpIssueFirst, fpIssueSecond}, 2'h1);
		cpCondValid <= 1'b0;
		repeat (2) @(posedge mclk);
		check({pipeStall, fpIssueSecond}, 2'h2);
		cpCondValid <= 1'b1;
		decodeFpSecond <= 1'b0;
		checkerSelectN <= 1'b0;
		@(posedge mclk);
		check(iuToFpuParityOe, 1'b0);
		checkerSelectN <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask : t_modes
	task automatic t_irq;
		irqLevel <= 4'hF;
		for (n = 0; n < 20 && !irqTakenAck; n++) @(posedge mclk);
		check(irqTakenAck, 1'b1);
		irqLevel <= 4'h0;
		axi_rd(fpt_pkg::ADDR_TRAP);
		check(rd[7:0], fpt_pkg::TT_IRQ_BASE + 8'h0F);
	endtask : t_irq
	task automatic t_error;
		axi_wr(fpt_pkg::ADDR_CTRL, 32'h0000_0000);
		syncTrapReq <= 1'b1;
		syncTrapType <= 8'h2A;
		@(posedge mclk);
		syncTrapReq <= 1'b0;
		repeat (8) @(posedge mclk);
		check(errorMode, 1'b1);
		axi_rd(fpt_pkg::ADDR_TRAP);
		check(rd[7:0], 8'h2A);
	endtask : t_error
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_exc();
		t_pipe();
		t_modes();
		t_irq();
		t_error();
		rst <= 1'b1;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check(errorMode, 1'b0);
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		end_sim();
	end
endmodule : fpt_trap_ctrl_tb
bind fpt_trap_ctrl fpt_trap_ctrl_props fpt_trap_ctrl_props_i (.mclk(mclk), .rst(rst), .fetchReq(fetchReq),
	.fpHold(fpHold), .pipeStall(pipeStall), .trapTaken(trapTaken), .fpIssueFirst(fpIssueFirst),
	.fpIssueSecond(fpIssueSecond), .fpFlush(fpFlush), .fpExceptionAck(fpExceptionAck),
	.instrFetchStrobe(instrFetchStrobe), .iuToFpuParity(iuToFpuParity), .iuToFpuParityOe(iuToFpuParityOe),
	.errorMode(errorMode), .irqTakenAck(irqTakenAck));
